// File: shared/mmu_defines.svh
// offsets, field positions, reset values and decode constants
// assumes a 32-bit apb with byte addresses in the low eight bits
`ifndef MMU_DEFINES_SVH
`define MMU_DEFINES_SVH
// apb register byte offsets
`define OFS_SR0        8'h00
`define OFS_SR1        8'h04
`define OFS_SR2        8'h08
`define OFS_SR3        8'h0C
`define OFS_STAT       8'h10
`define OFS_PBASE      8'h40
`define OFS_PDESC      8'h60
// field positions
`define SR0_RELOC      0
`define DESC_ACC       7
`define DESC_WR        6
// reset values
`define SR_RST         16'h0000
// processor time state codes
`define TS_T1          3'h1
`define TS_T2          3'h2
`define TS_T3          3'h3
`define TS_T4          3'h4
`define TS_T5          3'h5
// internal register addresses
`define VA_SR0         16'hFF7A
`define VA_SR1         16'hFF7C
`define VA_SR2         16'hFF7E
`define PA_SR3         18'h3F54E
`define PA_PAGE_BLK    12'hFD3
`define VA_IO_PAGE     3'h7
`endif

// File: shared/mmu_pkg.sv
// types shared by the register access block
// assumes mmu_defines.svh holds the numbers
package mmu_pkg;
   // read-back multiplexer select code
   typedef enum logic [1:0] {
      SEL_SR0  = 2'b00,
      SEL_SR1  = 2'b01,
      SEL_SR2  = 2'b10,
      SEL_PAGE = 2'b11
   } rb_sel_t;
   // memory cycle phase
   typedef enum logic {
      PH_ADDR = 1'b0,
      PH_DATA = 1'b1
   } phase_t;
   typedef logic [15:0] word_t;
endpackage

// File: shared/pin_sync_if.sv
// bundle of raw pin levels and their synchronised copies
// assumes one clock for both sides
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(parameter int W = 59);
   logic [W-1:0] raw;   // pin levels
   logic [W-1:0] clean; // settled levels
   modport syn (input raw, output clean);
   modport usr (output raw, input clean);
endinterface
`default_nettype wire

// File: design/pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes raw levels from outside the MCLK domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(parameter int W = 59) (
   input wire logic MCLK,  // system clock
   input wire logic RST_N, // sync reset, low
   pin_sync_if.syn  pins   // raw in, clean out
);
   logic [W-1:0] s1_ff; // first stage, read by s2 only
   logic [W-1:0] s2_ff; // second stage
   logic [W-1:0] s3_ff; // third stage
   logic [W-1:0] cl_ff; // accepted level

   ////////////////////////////////////////////////////////////////////
   // shift chain and per-bit agreement
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         cl_ff <= '0;
      end else begin
         s1_ff <= pins.raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         // bit changes only once stages two and three agree
         cl_ff <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & cl_ff);
      end
   end
   assign pins.clean = cl_ff;
endmodule
`default_nettype wire

// File: design/mmu_reg_access.sv
// mmu internal register read-back and access timing
// assumes processor time-state pins and an apb master on MCLK
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mmu_defines.svh"
module mmu_reg_access (
   input  wire logic          MCLK,        // 25 MHz clock
   input  wire logic          RST_N,       // sync reset, low
   input  wire logic          PSEL,        // apb select
   input  wire logic          PENABLE,     // apb access phase
   input  wire logic          PWRITE,      // apb direction
   input  wire logic [7:0]    PADDR,       // apb byte address
   input  wire logic [31:0]   PWDATA,      // apb write data
   output logic      [31:0]   PRDATA,      // apb read data
   output logic               PREADY,      // apb ready
   output logic               PSLVERR,     // apb error
   input  wire logic [2:0]    TS,          // processor time state
   input  wire mmu_pkg::phase_t DPHASE,    // address or data phase
   input  wire logic          CYCLE_CTL,   // cycle control bit
   input  wire logic          BUS_YIELD,   // bus yield request
   input  wire logic [15:0]   VADDR,       // virtual address
   input  wire logic          WR_TXN,      // write transaction
   input  wire logic          SVC_BREAK,   // service break state
   input  wire logic          INSTR_LOAD,  // instr load field
   input  wire logic [15:0]   BUF_DATA,    // processor buffer reg
   input  wire logic          PAGE_ERR,    // paging error seen
   input  wire logic [15:0]   AUTO_MOD,    // register modify info
   input  wire logic          AUTO_VALID,  // modify info present
   output logic [15:0]        INT_BUS,     // internal data bus
   output logic               INT_BUS_OE,  // internal bus enable
   output logic               FAST_ACK,    // fast acknowledge
   output logic [17:0]        PHYS_ADDR    // physical address
);
   import mmu_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisation
   pin_sync_if #(.W(59)) pins ();          // pin bundle
   assign pins.raw = {TS, DPHASE, CYCLE_CTL, BUS_YIELD, VADDR, WR_TXN,
                      SVC_BREAK, INSTR_LOAD, BUF_DATA, PAGE_ERR,
                      AUTO_MOD, AUTO_VALID};
   pin_sync #(.W(59)) u_sync (
      .MCLK  (MCLK),
      .RST_N (RST_N),
      .pins  (pins.syn)
   );
   logic [2:0]  ts;       // settled time state
   logic        ph_raw;   // settled phase bit
   phase_t      ph;       // settled phase
   logic        cyc;      // settled cycle bit
   logic        yld;      // settled yield
   logic [15:0] va;       // settled address
   logic        wr;       // settled direction
   logic        brk;      // settled break
   logic        ild;      // settled load field
   logic [15:0] bd;       // settled buffer data
   logic        perr;     // settled error
   logic [15:0] amod;     // settled modify info
   logic        aval;     // settled modify valid
   assign {ts, ph_raw, cyc, yld, va, wr, brk, ild, bd, perr, amod, aval} =
      pins.clean;
   assign ph = phase_t'(ph_raw); // enum needs an explicit cast

   ////////////////////////////////////////////////////////////////////
   // helpers
   // relocate: page base in 64-byte units plus page offset
   function automatic logic [17:0] reloc(input logic [15:0] v,
                                         input logic [15:0] b);
      reloc = {b[11:0], 6'h00} + {5'h00, v[12:0]};
   endfunction
   // status select code from address bits
   function automatic rb_sel_t sel_code(input logic [1:0] a,
                                        input logic pg);
      if (pg)
         sel_code = SEL_PAGE;
      else if (a == 2'h1)
         sel_code = SEL_SR0;
      else if (a == 2'h2)
         sel_code = SEL_SR1;
      else
         sel_code = SEL_SR2;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // state
   word_t       sr0_ff;         // status zero
   word_t       sr1_ff;         // status one
   word_t       sr2_ff;         // status two
   word_t       sr3_ff;         // status three
   word_t       pbase_ff [8];   // page base regs
   word_t       pdesc_ff [8];   // page descriptor regs
   logic [2:0]  ts_prev_ff;     // last time state
   logic        shit_ff;        // status_reg_hit
   logic        phit_ff;        // page_reg_hit
   logic        sr3hit_ff;      // status three hit
   logic [2:0]  pidx_ff;        // page reg index
   logic        pbsel_ff;       // base (1) or descriptor (0)
   logic        fack_ff;        // fast_acknowledge
   logic        brk_dec_ff;     // decoded break state
   logic        ild_dec_ff;     // decoded load field
   logic        sr1_hold_ff;    // status one held clear
   logic        noerr_ff;       // no-error flag
   logic [15:0] bus_ff;         // bus data out
   logic        oe_ff;          // bus enable out
   logic [17:0] pa_ff;          // physical address out
   logic [31:0] prdata_ff;      // apb read data
   logic        pready_ff;      // apb ready
   logic        pslverr_ff;     // apb error

   ////////////////////////////////////////////////////////////////////
   // time state entry strobes
   logic [2:0]  ts_prev;        // alias for clarity
   assign ts_prev = ts_prev_ff;
   logic at_t1;                 // entered T1
   logic at_t2;                 // entered T2
   logic at_t3;                 // entered T3
   logic at_t4;                 // entered T4
   logic at_t5;                 // entered T5
   // events fire once, on the edge where the state changes
   assign at_t1 = (ts != ts_prev) && (ts == `TS_T1);
   assign at_t2 = (ts != ts_prev) && (ts == `TS_T2);
   assign at_t3 = (ts != ts_prev) && (ts == `TS_T3);
   assign at_t4 = (ts != ts_prev) && (ts == `TS_T4);
   assign at_t5 = (ts != ts_prev) && (ts == `TS_T5);
   logic is_addr;               // address-phase cycle
   assign is_addr = (ph == PH_ADDR);

   // previous time state
   always_ff @(posedge MCLK) begin
      if (!RST_N)
         ts_prev_ff <= 3'h0;
      else
         ts_prev_ff <= ts;
   end

   ////////////////////////////////////////////////////////////////////
   // address path
   logic        relocating;     // relocation enabled
   logic [17:0] pa_now;         // mapped address
   logic        io_page;        // top virtual page
   assign relocating = sr0_ff[`SR0_RELOC];
   assign io_page    = (va[15:13] == `VA_IO_PAGE);
   // kernel base drops out once the fast acknowledge is up
   assign pa_now = !relocating ? {2'h0, va} :
                   fack_ff ? {2'h0, va} :
                   reloc(va, pbase_ff[va[15:13]]);
   logic dec_stat;              // status address decoded
   logic dec_page;              // page reg decoded
   logic dec_sr3;               // status three decoded
   logic [17:0] pa_dec;         // address used for decode
   assign pa_dec   = (!relocating && io_page) ? {2'h3, va} : pa_now;
   // status hit looks only at the three status addresses
   assign dec_stat = (va == `VA_SR0) || (va == `VA_SR1) ||
                     (va == `VA_SR2);
   assign dec_page = (pa_dec[17:6] == `PA_PAGE_BLK);
   assign dec_sr3  = (pa_dec == `PA_SR3);

   ////////////////////////////////////////////////////////////////////
   // hit and acknowledge flops
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         shit_ff   <= 1'b0;
         phit_ff   <= 1'b0;
         sr3hit_ff <= 1'b0;
         fack_ff   <= 1'b0;
         pidx_ff   <= 3'h0;
         pbsel_ff  <= 1'b0;
      end else if (is_addr && (ts == `TS_T1)) begin
         // held clear throughout address-phase T1
         shit_ff   <= 1'b0;
         phit_ff   <= 1'b0;
         sr3hit_ff <= 1'b0;
         fack_ff   <= 1'b0;
      end else if (is_addr && at_t5) begin
         shit_ff   <= dec_stat;
         phit_ff   <= dec_page;
         sr3hit_ff <= dec_sr3;
         // any internal register acknowledges as fast
         fack_ff   <= dec_stat | dec_page | dec_sr3;
         pidx_ff   <= va[3:1];
         pbsel_ff  <= va[5];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // microstate decode, both phases
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         brk_dec_ff <= 1'b0;
         ild_dec_ff <= 1'b0;
      end else if (at_t2) begin
         brk_dec_ff <= brk;
         ild_dec_ff <= ild;
      end
   end

   // status one clear hold until next cycle start
   always_ff @(posedge MCLK) begin
      if (!RST_N)
         sr1_hold_ff <= 1'b0;
      else if (at_t2 && (brk || ild))
         sr1_hold_ff <= 1'b1;
      else if (at_t1)
         sr1_hold_ff <= 1'b0;
   end

   // no-error flag at T1 of the following cycle
   always_ff @(posedge MCLK) begin
      if (!RST_N)
         noerr_ff <= 1'b1;
      else if (at_t1)
         noerr_ff <= !perr;
   end

   ////////////////////////////////////////////////////////////////////
   // apb decode
   logic       apb_wr;          // apb write accepted
   logic       apb_acc;         // access phase, not yet answered
   logic [7:0] apb_a;           // aligned offset
   logic       apb_pg;          // page reg window
   assign apb_acc = PSEL && PENABLE && !pready_ff;
   assign apb_wr  = apb_acc && PWRITE;
   assign apb_a   = {PADDR[7:2], 2'b00};
   assign apb_pg  = (apb_a >= `OFS_PBASE);

   ////////////////////////////////////////////////////////////////////
   // status registers
   logic sr0_prog;              // processor writes status zero
   // write permitted only with status hit already set
   assign sr0_prog = is_addr == 1'b0 && at_t3 && shit_ff && wr && cyc &&
                     (sel_code(va[2:1], 1'b0) == SEL_SR0);
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         sr0_ff <= `SR_RST;
      end else if (sr0_prog) begin
         sr0_ff <= bd;
      end else if (!is_addr && at_t3 && relocating && noerr_ff &&
                   !fack_ff) begin
         sr0_ff[3:1] <= va[15:13];
      end else if (apb_wr && apb_a == `OFS_SR0) begin
         sr0_ff <= PWDATA[15:0];
      end
   end

   // status one: cleared while held, else modify info at T5
   always_ff @(posedge MCLK) begin
      if (!RST_N)
         sr1_ff <= `SR_RST;
      else if (sr1_hold_ff)
         sr1_ff <= `SR_RST;
      else if (at_t5 && aval)
         sr1_ff <= amod;
   end

   // status two: address of each new sequence at T4
   always_ff @(posedge MCLK) begin
      if (!RST_N)
         sr2_ff <= `SR_RST;
      else if (at_t4 && is_addr && (ild_dec_ff || brk_dec_ff))
         sr2_ff <= va;
   end

   // status three at data-phase T5
   always_ff @(posedge MCLK) begin
      if (!RST_N)
         sr3_ff <= `SR_RST;
      else if (!is_addr && at_t5 && sr3hit_ff && wr)
         sr3_ff <= bd;
      else if (apb_wr && apb_a == `OFS_SR3)
         sr3_ff <= PWDATA[15:0];
   end

   ////////////////////////////////////////////////////////////////////
   // page registers
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         for (int i = 0; i < 8; i++) begin
            pbase_ff[i] <= `SR_RST;
            pdesc_ff[i] <= `SR_RST;
         end
      end else if (!is_addr && at_t4 && phit_ff && wr) begin
         // buffer data stored at data-phase T4
         if (pbsel_ff)
            pbase_ff[pidx_ff] <= bd;
         else
            pdesc_ff[pidx_ff] <= bd;
      end else if (is_addr && at_t5 && relocating && !dec_page) begin
         // access and written flags of the mapped page
         pdesc_ff[va[15:13]][`DESC_ACC] <= 1'b1;
         if (wr)
            pdesc_ff[va[15:13]][`DESC_WR] <= 1'b1;
      end else if (apb_wr && apb_pg) begin
         if (apb_a < `OFS_PDESC)
            pbase_ff[apb_a[4:2]] <= PWDATA[15:0];
         else
            pdesc_ff[apb_a[4:2]] <= PWDATA[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read-back multiplexer
   rb_sel_t sel;                // chosen source
   word_t   page_src;           // base or descriptor
   word_t   rb_word;            // selected word
   assign sel      = sel_code(va[2:1], phit_ff);
   assign page_src = pbsel_ff ? pbase_ff[pidx_ff] :
                                pdesc_ff[pidx_ff];
   always_comb begin
      unique case (sel)
         SEL_SR0:  rb_word = sr0_ff;
         SEL_SR1:  rb_word = sr1_ff;
         SEL_SR2:  rb_word = sr2_ff;
         SEL_PAGE: rb_word = page_src;
      endcase
   end

   // bus drive registered; yield assumed only for shared ops
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         oe_ff  <= 1'b0;
         bus_ff <= 16'h0000;
      end else begin
         oe_ff  <= cyc && (shit_ff || phit_ff) && !yld;
         bus_ff <= (cyc && (shit_ff || phit_ff) && !yld && !wr) ?
                   rb_word : 16'h0000;
      end
   end

   // physical address out
   always_ff @(posedge MCLK) begin
      if (!RST_N)
         pa_ff <= 18'h00000;
      else
         pa_ff <= pa_now;
   end

   ////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, error on unmapped offsets
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h00000000;
         pslverr_ff <= 1'b0;
      end else if (apb_acc) begin
         pready_ff  <= 1'b1;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
         if (apb_pg && apb_a < `OFS_PDESC + 8'h20) begin
            prdata_ff[15:0] <= (apb_a < `OFS_PDESC) ?
               pbase_ff[apb_a[4:2]] : pdesc_ff[apb_a[4:2]];
         end else begin
            unique case (apb_a)
               `OFS_SR0:  prdata_ff[15:0] <= sr0_ff;
               `OFS_SR1:  prdata_ff[15:0] <= sr1_ff;
               `OFS_SR2:  prdata_ff[15:0] <= sr2_ff;
               `OFS_SR3:  prdata_ff[15:0] <= sr3_ff;
               `OFS_STAT: prdata_ff[7:0]  <= {fack_ff, phit_ff, shit_ff,
                                              noerr_ff, sr1_hold_ff, ts};
               default:   pslverr_ff      <= 1'b1;
            endcase
         end
      end else begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign PRDATA     = prdata_ff;
   assign PREADY     = pready_ff;
   assign PSLVERR    = pslverr_ff;
   assign INT_BUS    = bus_ff;
   assign INT_BUS_OE = oe_ff;
   assign FAST_ACK   = fack_ff;
   assign PHYS_ADDR  = pa_ff;
endmodule
`default_nettype wire

// File: tb/reg_access_props.sv
// port checker for the register access block
// assumes a bind to mmu_reg_access and one clock
`timescale 1ns/1ps
`default_nettype none
`include "mmu_defines.svh"
module reg_access_props (
   input wire logic            MCLK,       // clock
   input wire logic            RST_N,      // reset
   input wire logic            PSEL,       // select
   input wire logic            PENABLE,    // access
   input wire logic [31:0]     PRDATA,     // read data
   input wire logic            PREADY,     // ready
   input wire logic            PSLVERR,    // error
   input wire logic [2:0]      TS,         // time state
   input wire mmu_pkg::phase_t DPHASE,     // phase
   input wire logic            CYCLE_CTL,  // cycle bit
   input wire logic            BUS_YIELD,  // yield
   input wire logic [15:0]     INT_BUS,    // read-back
   input wire logic            INT_BUS_OE, // enable
   input wire logic            FAST_ACK,   // acknowledge
   input wire logic [17:0]     PHYS_ADDR   // address
);
   import mmu_pkg::*;
   // single domain
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   ////////////////////
   // apb handshake
   ready_answer_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("access not answered");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready held too long");
   err_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   rdata_upper_a: assert property (PREADY |-> PRDATA[31:16] == 16'h0000)
      else $error("upper read bits set");
   ////////////////////
   // read-back and acknowledge
   bus_idle_a: assert property (!INT_BUS_OE |-> INT_BUS == 16'h0000)
      else $error("bus word while disabled");
   bus_enable_a: assert property (INT_BUS_OE |-> $past(FAST_ACK) &&
      ($past(CYCLE_CTL, 5) || $past(CYCLE_CTL, 6)) &&
      (!$past(BUS_YIELD, 5) || !$past(BUS_YIELD, 6)))
      else $error("bus enabled without cause");
   ack_rise_a: assert property ($rose(FAST_ACK) |->
      $past(DPHASE, 5) == PH_ADDR &&
      ($past(TS, 5) == `TS_T5 || $past(TS, 6) == `TS_T5))
      else $error("ack rose outside T5");
   ack_fall_a: assert property ($fell(FAST_ACK) |->
      $past(DPHASE, 5) == PH_ADDR &&
      ($past(TS, 5) == `TS_T1 || $past(TS, 6) == `TS_T1))
      else $error("ack fell outside T1");
   ack_phys_a: assert property (FAST_ACK && $past(FAST_ACK) |->
      PHYS_ADDR[17:16] == 2'b00)
      else $error("kernel base not deselected");
endmodule
bind mmu_reg_access reg_access_props i_props (.*);
`default_nettype wire

// File: tb/cpu_model.sv
// processor model: time states and memory cycle fields
// assumes MCLK shared with the block; run is called by tb
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
   input  wire logic        MCLK,       // clock
   output logic [2:0]       TS,         // time state
   output mmu_pkg::phase_t  DPHASE,     // phase
   output logic             CYCLE_CTL,  // cycle bit
   output logic             BUS_YIELD,  // yield
   output logic [15:0]      VADDR,      // address
   output logic             WR_TXN,     // write
   output logic             SVC_BREAK,  // break state
   output logic             INSTR_LOAD, // load field
   output logic [15:0]      BUF_DATA,   // buffer reg
   input  wire logic [15:0] INT_BUS,    // read-back
   input  wire logic        INT_BUS_OE, // enable
   input  wire logic        FAST_ACK,   // acknowledge
   input  wire logic [17:0] PHYS_ADDR   // address
);
   import mmu_pkg::*;
   // idle levels
   initial begin
      {TS, CYCLE_CTL, BUS_YIELD, WR_TXN, SVC_BREAK, INSTR_LOAD} = '0;
      DPHASE = PH_ADDR;
      VADDR = 16'h0000;
      BUF_DATA = 16'hFFFF;
   end
   // address phase then data phase, six cycles a state
   task automatic run(input logic [15:0] va, bd, input logic wr, yl,
      input logic [1:0] brk, output logic fa, oe,
      output logic [15:0] ib, output logic [17:0] pa);
      for (int s = 0; s < 10; s++) begin
         @(posedge MCLK);
         TS <= 3'(s % 5 + 1);
         DPHASE <= phase_t'(s / 5);
         CYCLE_CTL <= s > 5;         // data T2..T5
         BUS_YIELD <= yl && s > 5;   // shared ops only
         if (s == 0) begin
            VADDR <= va;
            WR_TXN <= wr;
            BUF_DATA <= bd;
            {INSTR_LOAD, SVC_BREAK} <= brk;
         end
         repeat (5) @(posedge MCLK); // delay periods
         if (s == 5) begin           // fast cycle goes on
            fa = FAST_ACK;
            pa = PHYS_ADDR;
         end
         if (s == 8) begin
            oe = INT_BUS_OE;
            ib = INT_BUS;
         end
      end
      @(posedge MCLK);
      {TS, CYCLE_CTL, BUS_YIELD, SVC_BREAK, INSTR_LOAD} <= '0;
      BUF_DATA <= ~bd;               // released bus
      repeat (5) @(posedge MCLK);    // idle state held like any other
   endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the register access block
// assumes cpu_model on the processor side, checker bound
`timescale 1ns/1ps
`default_nettype none
`include "mmu_defines.svh"
module tb;
   import mmu_pkg::*;
   logic        MCLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic        CYCLE_CTL, BUS_YIELD, WR_TXN, SVC_BREAK, INSTR_LOAD;
   logic        PAGE_ERR, AUTO_VALID, INT_BUS_OE, FAST_ACK, fa, oe;
   logic [2:0]  TS;                       // time state
   phase_t      DPHASE;                   // phase
   logic [7:0]  PADDR;                    // apb address
   logic [31:0] PWDATA, PRDATA;           // apb data
   logic [15:0] VADDR, BUF_DATA, AUTO_MOD, INT_BUS, ib;
   logic [17:0] PHYS_ADDR, pa;            // addresses
   int          n_errors, samples_checked; // tallies
   mmu_reg_access i_mmu_reg_access (.*);
   cpu_model      i_cpu_model (.*);
   always #20 MCLK = ~MCLK;               // 25 MHz
   ////////////////////
   task automatic test_done();
      if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] g, x);
      samples_checked++;
      if (g !== x) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", nm, x, g);
      end
   endtask
   // one apb transfer, bounded wait for ready
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int k = 0;
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      // look between edges, where the registered answer has settled
      do begin
         @(negedge MCLK);
         k++;
      end while (!PREADY && k < 20);
      if (!PREADY) begin
         n_errors++;
         test_done();
      end
      r = PRDATA;
      e = PSLVERR;
      @(posedge MCLK);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check($sformatf("reg %h", a), r & m, x);
   endtask
   task automatic cyc(input logic [15:0] va, bd, input logic w, y,
      input logic [1:0] b);
      i_cpu_model.run(va, bd, w, y, b, fa, oe, ib, pa);
   endtask
   ////////////////////
   // reset values, refusals, read-only
   task automatic t_reset();
      logic [31:0] r;
      logic        e;
      rd(`OFS_SR0, '1, 32'h0);
      rd(`OFS_STAT, '1, 32'h10);
      apb(1'b0, 8'h20, 32'h0, r, e);         // unmapped
      check("unmapped data", r, 32'h0);
      check("unmapped err", 32'(e), 32'h1);
      wr(`OFS_SR1, 32'hFFFF);
      rd(`OFS_SR1, '1, 32'h0);               // read-only
   endtask
   // status zero write, yield, select, miss
   task automatic t_status();
      cyc(`VA_SR0, 16'h0001, 1'b1, 1'b0, 2'b00);
      check("sr0 ack", 32'(fa), 32'h1);
      rd(`OFS_SR0, 32'h1, 32'h1);
      cyc(`VA_SR0, 16'h0000, 1'b0, 1'b1, 2'b00);
      check("oe yield", 32'(oe), 32'h0);
      cyc(`VA_SR0, 16'h0000, 1'b0, 1'b0, 2'b00);
      check("oe read", 32'(oe), 32'h1);
      check("sr0 bus", 32'(ib[0]), 32'h1);
      cyc(16'hFF78, 16'h0000, 1'b0, 1'b0, 2'b00);
      check("no ack", 32'(fa), 32'h0);
      wr(`OFS_SR0, 32'h0);
   endtask
   // break and load both clear status one, load status two
   task automatic t_sr1();
      logic [15:0] va;
      for (int m = 1; m <= 2; m++) begin
         va = (m == 1) ? `VA_SR1 : 16'h0200;
         AUTO_MOD <= 16'h1234;
         AUTO_VALID <= 1'b1;
         cyc(16'h0100, 16'h0000, 1'b0, 1'b0, 2'b00);
         AUTO_VALID <= 1'b0;
         rd(`OFS_SR1, '1, 32'h1234);
         cyc(va, 16'h0000, 1'b0, 1'b0, 2'(m));
         rd(`OFS_SR1, '1, 32'h0);
         rd(`OFS_SR2, '1, 32'(va));
         if (m == 1) check("sr1 bus", 32'(ib), 32'h0);
      end
      cyc(`VA_SR2, 16'h0000, 1'b0, 1'b0, 2'b00);
      check("sr2 bus", 32'(ib), 32'h0200);
   endtask
   // page base and descriptor read, buffer write
   task automatic t_page();
      wr(`OFS_PBASE + 8'h0C, 32'h0ABC);
      wr(`OFS_PDESC + 8'h0C, 32'h0A0F);
      cyc(16'hF4E6, 16'h0000, 1'b0, 1'b0, 2'b00);
      check("page ack", 32'(fa), 32'h1);
      check("page phys", 32'(pa), 32'h0F4E6);
      check("page bus", 32'(ib), 32'h0ABC);
      cyc(16'hF4C6, 16'h0000, 1'b0, 1'b0, 2'b00);
      check("desc bus", 32'(ib), 32'h0A0F);
      cyc(16'hF4E6, 16'h0555, 1'b1, 1'b0, 2'b00);
      rd(`OFS_PBASE + 8'h0C, '1, 32'h0555);
      cyc(16'hF54E, 16'h0033, 1'b1, 1'b0, 2'b00);
      check("sr3 ack", 32'(fa), 32'h1);
      rd(`OFS_SR3, '1, 32'h0033);
   endtask
   // relocation on and off
   task automatic t_reloc();
      wr(`OFS_PBASE + 8'h04, 32'h0100);
      wr(`OFS_SR0, 32'h1);
      cyc(16'h2345, 16'h0000, 1'b0, 1'b0, 2'b00);
      check("reloc phys", 32'(pa), 32'h04345);
      cyc(`VA_SR0, 16'h0000, 1'b0, 1'b0, 2'b00);
      check("ack phys", 32'(pa), 32'h0FF7A);
      wr(`OFS_SR0, 32'h0);
      cyc(16'h2345, 16'h0000, 1'b0, 1'b0, 2'b00);
      check("flat phys", 32'(pa), 32'h02345);
   endtask
   ////////////////////
   initial begin
      MCLK = 1'b0;
      {RST_N, PSEL, PENABLE, PWRITE, PAGE_ERR, AUTO_VALID} = '0;
      PADDR = 8'h00;
      PWDATA = 32'h0;
      AUTO_MOD = 16'h0000;
      n_errors = 0;
      samples_checked = 0;
      repeat (12) @(posedge MCLK);
      RST_N <= 1'b1;
      repeat (8) @(posedge MCLK);
      t_reset();
      t_status();
      t_sr1();
      t_page();
      t_reloc();
      test_done();
   end
endmodule
`default_nettype wire
